// ==== pwr_state_consts.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the power-state manager
// Assumes: 40 MHz core clock, 32-bit classic Wishbone register bus
// Notes:   Definitions only
`ifndef PWR_STATE_CONSTS_SVH
`define PWR_STATE_CONSTS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define OFS_CTRL        6'h00
`define OFS_STATUS      6'h04
`define OFS_PERSIST     6'h08
`define OFS_ENERGY      6'h0c
`define OFS_IRQ_STATUS  6'h10
`define OFS_FW_CTRL     6'h14
`define OFS_FW_DATA     6'h18
`define OFS_FW_STATUS   6'h1c

// ==========================================================================
// Control register fields
`define CTRL_LP_EN      0
`define CTRL_HOST_GATE  1
`define CTRL_PWR_DOWN   2
`define CTRL_EEE_EN     3
`define CTRL_FW_HOLD    4

// Firmware control fields
`define FW_START        0
`define FW_DONE         1
`define FW_ABORT        2
`define FW_REBOOT       3

// ==========================================================================
// Reset values
`define CTRL_RST        5'h08
`define PERSIST_RST     32'h0000_3040
`define ENERGY_RST      8'h04

// ==========================================================================
// Timing
`define CLK_HZ          40000000
`define SEC_CYCLES      `CLK_HZ
`define BOOT_NS         1000
`define BOOT_CYCLES     ((`BOOT_NS * 40 + 999) / 1000)
`define QUIET_CYCLES    16'h0100
`define REFRESH_CYCLES  16'h0010
`define FW_WORDS        64
`define FW_SIG          32'h5a5a_a5a5

`endif

// ==== pwr_state_pkg.sv ====
// Purpose: Types of the power-state manager
// Assumes: Used with pwr_state_consts.svh
// Notes:   Types only
package pwr_state_pkg;

  // ========================================================================
  // Power states
  typedef enum logic [2:0] {
    ST_RESET_UP,
    ST_POWER_DOWN,
    ST_SCAN,
    ST_ANEG,
    ST_NORMAL,
    ST_LPI,
    ST_LOW_POWER
  } pwr_state_e;

  // Line-side inputs
  typedef struct packed {
    logic       energy;
    logic       flp;
    logic       link_up;
    logic       aneg_done;
    logic       lpi_request;
    logic       partner_wake;
    logic [1:0] speed;
  } line_in_s;

  // Domain enables toward the rest of the PHY
  typedef struct packed {
    logic gpio_en;
    logic led_en;
    logic mgmt_en;
    logic digital_run;
    logic tx_on;
    logic refresh;
  } domain_en_s;

endpackage : pwr_state_pkg

// ==== phy_power_state_manager.sv ====
// Purpose: Power-state sequencing, persistent-field save/restore, EEE idle, firmware boot select
// Assumes: Inputs synchronous to core_clk; Wishbone classic slave, one ack per access, a cycle after the strobe outside ST_RESET_UP and ST_LOW_POWER
// Notes:   Ack is registered, so every access outside ST_RESET_UP and ST_LOW_POWER takes one wait cycle
`timescale 1ns/1ps
`include "pwr_state_consts.svh"

module phy_power_state_manager (
  input  wire  logic                    core_clk,
  input  wire  logic                    rst,
  input  wire  logic                    clk_en,
  input  wire  logic [5:0]              wb_adr_i,
  input  wire  logic [31:0]             wb_dat_i,
  input  wire  logic [3:0]              wb_sel_i,
  input  wire  logic                    wb_we_i,
  input  wire  logic                    wb_cyc_i,
  input  wire  logic                    wb_stb_i,
  input  wire  pwr_state_pkg::line_in_s line_i,
  output logic [31:0]                   wb_dat_o,
  output logic                          wb_ack_o,
  output pwr_state_pkg::domain_en_s     domain_o,
  output logic                          run_ram_image,
  output logic [2:0]                    state_o
);
  import pwr_state_pkg::*;

  // ========================================================================
  // State
  pwr_state_e  state_r,   state_nxt;
  logic [4:0]  ctrl_r,    ctrl_nxt;
  logic [31:0] persist_r, persist_nxt;
  logic [31:0] saved_r,   saved_nxt;
  logic [7:0]  energy_r,  energy_nxt;
  logic [7:0]  esave_r,   esave_nxt;
  logic [31:0] cnt_r,     cnt_nxt;
  logic [7:0]  sec_r,     sec_nxt;
  logic        pend_r,    pend_nxt;
  logic        seen_r,    seen_nxt;
  logic        phase_r,   phase_nxt;
  logic [15:0] eee_r,     eee_nxt;
  logic [31:0] fw_mem [0:`FW_WORDS-1];
  logic [5:0]  fw_ptr_r,  fw_ptr_nxt;
  logic [1:0]  fw_st_r,   fw_st_nxt;
  logic        ram_img_r, ram_img_nxt;
  logic        ack_r,     ack_nxt;
  logic [31:0] dat_r,     dat_nxt;
  domain_en_s  dom_r,     dom_nxt;

  logic        req;
  logic        wr;
  logic        rd;
  logic        mgmt_ok;

  // Bus is answered only while management is up
  assign mgmt_ok = state_r != ST_LOW_POWER && state_r != ST_RESET_UP;
  assign req     = wb_cyc_i && wb_stb_i && !ack_r && mgmt_ok;
  assign wr      = req && wb_we_i;
  assign rd      = req && !wb_we_i;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // ========================================================================
  // Next-state logic
  always_comb begin
    state_nxt   = state_r;
    ctrl_nxt    = ctrl_r;
    persist_nxt = persist_r;
    saved_nxt   = saved_r;
    energy_nxt  = energy_r;
    esave_nxt   = esave_r;
    cnt_nxt     = cnt_r;
    sec_nxt     = sec_r;
    pend_nxt    = pend_r;
    seen_nxt    = seen_r;
    phase_nxt   = phase_r;
    eee_nxt     = eee_r;
    fw_ptr_nxt  = fw_ptr_r;
    fw_st_nxt   = fw_st_r;
    ram_img_nxt = ram_img_r;
    ack_nxt     = req;
    dat_nxt     = dat_r;

    // Register writes
    if (wr) begin
      unique case (wb_adr_i)
        `OFS_CTRL:    ctrl_nxt    = 5'(merge({27'h0, ctrl_r}, wb_dat_i, wb_sel_i));
        `OFS_PERSIST: persist_nxt = merge(persist_r, wb_dat_i, wb_sel_i);
        `OFS_ENERGY:  energy_nxt  = 8'(merge({24'h0, energy_r}, wb_dat_i, wb_sel_i));
        `OFS_FW_CTRL: begin
          if (wb_dat_i[`FW_START]) begin
            fw_ptr_nxt = 6'h0;
            fw_st_nxt  = 2'h1;
          end
          if (wb_dat_i[`FW_ABORT]) begin
            fw_st_nxt = 2'h3;
          end
          if (wb_dat_i[`FW_DONE] && fw_st_r == 2'h1) begin
            fw_st_nxt = (fw_mem[0] == `FW_SIG) ? 2'h2 : 2'h3;
          end
          if (wb_dat_i[`FW_REBOOT]) begin
            ram_img_nxt = fw_st_r == 2'h2;
            state_nxt   = ST_RESET_UP;
            cnt_nxt     = 32'h0;
          end
        end
        `OFS_FW_DATA: begin
          if (fw_st_r == 2'h1) begin
            fw_ptr_nxt = fw_ptr_r + 6'h1;
          end
        end
        default: ;
      endcase
    end

    // Register reads
    if (rd) begin
      unique case (wb_adr_i)
        `OFS_CTRL:       dat_nxt = {27'h0, ctrl_r};
        `OFS_STATUS:     dat_nxt = {24'h0, line_i.link_up, line_i.energy, pend_r,
                                    2'h0, 3'(state_r)};
        `OFS_PERSIST:    dat_nxt = persist_r;
        `OFS_ENERGY:     dat_nxt = {24'h0, energy_r};
        `OFS_IRQ_STATUS: dat_nxt = {31'h0, pend_r};
        `OFS_FW_STATUS:  dat_nxt = {23'h0, ram_img_r, fw_ptr_r, fw_st_r};
        default:         dat_nxt = 32'h0;
      endcase
      if (wb_adr_i == `OFS_IRQ_STATUS) begin
        seen_nxt = pend_r;
      end
    end

    if (!wr || wb_adr_i != `OFS_FW_CTRL || !wb_dat_i[`FW_REBOOT]) begin
      unique case (state_r)
        ST_RESET_UP: begin
          cnt_nxt = cnt_r + 32'h1;
          if (cnt_r >= 32'(`BOOT_CYCLES) - 32'h1 && !ctrl_r[`CTRL_FW_HOLD]) begin
            state_nxt = ST_SCAN;
            cnt_nxt   = 32'h0;
            sec_nxt   = 8'h0;
          end
        end
        ST_POWER_DOWN: begin
          if (!ctrl_r[`CTRL_PWR_DOWN]) begin
            state_nxt = ST_SCAN;
          end
        end
        ST_SCAN: begin
          if (line_i.energy || line_i.flp) begin
            cnt_nxt  = 32'h0;
            sec_nxt  = 8'h0;
            pend_nxt = 1'b0;
            seen_nxt = 1'b0;
            if (line_i.flp) begin
              state_nxt = ST_ANEG;
            end
          end else if (ctrl_r[`CTRL_LP_EN]) begin
            if (sec_r < energy_r) begin
              cnt_nxt = cnt_r + 32'h1;
              if (cnt_r == 32'(`SEC_CYCLES) - 32'h1) begin
                cnt_nxt = 32'h0;
                sec_nxt = sec_r + 8'h1;
              end
            end else begin
              pend_nxt = 1'b1;
              if (!ctrl_r[`CTRL_HOST_GATE] || seen_r) begin
                state_nxt = ST_LOW_POWER;
                saved_nxt = persist_r;
                esave_nxt = energy_r;
                pend_nxt  = 1'b0;
                seen_nxt  = 1'b0;
              end
            end
          end
        end
        ST_ANEG: begin
          if (line_i.aneg_done && line_i.link_up) begin
            state_nxt = ST_NORMAL;
          end else if (!line_i.energy && !line_i.flp) begin
            state_nxt = ST_SCAN;
          end
        end
        ST_NORMAL: begin
          if (!line_i.link_up) begin
            state_nxt = ST_SCAN;
          end else if (ctrl_r[`CTRL_EEE_EN] && line_i.lpi_request) begin
            state_nxt = ST_LPI;
            phase_nxt = 1'b0;
            eee_nxt   = 16'h0;
          end
        end
        ST_LPI: begin
          eee_nxt = eee_r + 16'h1;
          if (!line_i.link_up) begin
            state_nxt = ST_SCAN;
          end else if (line_i.partner_wake || !line_i.lpi_request) begin
            state_nxt = ST_NORMAL;
          end else if (!phase_r && eee_r == `QUIET_CYCLES - 16'h1) begin
            phase_nxt = 1'b1;
            eee_nxt   = 16'h0;
          end else if (phase_r && eee_r == `REFRESH_CYCLES - 16'h1) begin
            phase_nxt = 1'b0;
            eee_nxt   = 16'h0;
          end
        end
        ST_LOW_POWER: begin
          if (line_i.energy || line_i.flp) begin
            state_nxt   = ST_RESET_UP;
            cnt_nxt     = 32'h0;
            persist_nxt = saved_r;
            energy_nxt  = esave_r;
            ctrl_nxt    = `CTRL_RST;
            ctrl_nxt[`CTRL_LP_EN]    = ctrl_r[`CTRL_LP_EN];
            ctrl_nxt[`CTRL_HOST_GATE] = ctrl_r[`CTRL_HOST_GATE];
          end
        end
        default: state_nxt = ST_RESET_UP;
      endcase
      if (ctrl_r[`CTRL_PWR_DOWN] && state_r != ST_LOW_POWER && state_r != ST_RESET_UP) begin
        state_nxt = ST_POWER_DOWN;
      end
    end
  end

  // Domain enables by state
  always_comb begin
    dom_nxt             = '0;
    dom_nxt.gpio_en     = state_nxt != ST_LOW_POWER;
    dom_nxt.led_en      = state_nxt != ST_LOW_POWER;
    dom_nxt.mgmt_en     = state_nxt != ST_LOW_POWER;
    dom_nxt.digital_run = state_nxt != ST_LOW_POWER;
    dom_nxt.tx_on       = state_nxt == ST_ANEG || state_nxt == ST_NORMAL ||
                          (state_nxt == ST_LPI && phase_nxt);
    dom_nxt.refresh     = state_nxt == ST_LPI && phase_nxt;
  end

  // ========================================================================
  // Registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r   <= ST_RESET_UP;
      ctrl_r    <= `CTRL_RST;
      persist_r <= `PERSIST_RST;
      saved_r   <= `PERSIST_RST;
      energy_r  <= `ENERGY_RST;
      esave_r   <= `ENERGY_RST;
      cnt_r     <= 32'h0;
      sec_r     <= 8'h0;
      pend_r    <= 1'b0;
      seen_r    <= 1'b0;
      phase_r   <= 1'b0;
      eee_r     <= 16'h0;
      fw_ptr_r  <= 6'h0;
      fw_st_r   <= 2'h0;
      ram_img_r <= 1'b0;
      ack_r     <= 1'b0;
      dat_r     <= 32'h0;
      dom_r     <= '0;
    end else if (clk_en) begin
      state_r   <= state_nxt;
      ctrl_r    <= ctrl_nxt;
      persist_r <= persist_nxt;
      saved_r   <= saved_nxt;
      energy_r  <= energy_nxt;
      esave_r   <= esave_nxt;
      cnt_r     <= cnt_nxt;
      sec_r     <= sec_nxt;
      pend_r    <= pend_nxt;
      seen_r    <= seen_nxt;
      phase_r   <= phase_nxt;
      eee_r     <= eee_nxt;
      fw_ptr_r  <= fw_ptr_nxt;
      fw_st_r   <= fw_st_nxt;
      ram_img_r <= ram_img_nxt;
      ack_r     <= ack_nxt;
      dat_r     <= dat_nxt;
      dom_r     <= dom_nxt;
    end
  end

  // Image memory, no reset
  always_ff @(posedge core_clk) begin
    if (clk_en && wr && wb_adr_i == `OFS_FW_DATA && fw_st_r == 2'h1) begin
      fw_mem[fw_ptr_r] <= wb_dat_i;
    end
  end

  assign wb_ack_o      = ack_r;
  assign wb_dat_o      = dat_r;
  assign domain_o      = dom_r;
  assign run_ram_image = ram_img_r;
  assign state_o       = 3'(state_r);

endmodule : phy_power_state_manager

// ==== pwr_mgr_asserts.sv ====
// Purpose: Port checks of the power-state manager
// Assumes: One clock, reset active high
// Notes:   Bound below
`timescale 1ns/1ps
module pwr_mgr_checker (
  input wire logic                    core_clk,
  input wire logic                    rst,
  input wire logic                    clk_en,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire pwr_state_pkg::line_in_s line_i,
  input wire logic                    wb_ack_o,
  input wire pwr_state_pkg::domain_en_s domain_o,
  input wire logic [2:0]              state_o
);
  import pwr_state_pkg::*;
  logic [9:0] quiet_r;
  logic [9:0] quiet_nxt;
  // ==========================================
  // Quiet run length
  always_comb begin
    quiet_nxt = 10'h0;
    if (!clk_en) quiet_nxt = quiet_r;
    else if (state_o == 3'h5 && !domain_o.tx_on) quiet_nxt = quiet_r + 10'h1;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) quiet_r <= 10'h0;
    else quiet_r <= quiet_nxt;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Properties
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_ack_prompt: assert property (clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o
    && !(state_o inside {3'h0, 3'h6}) |=> wb_ack_o) else $error("request not acked");
  a_no_ack_lp: assert property (clk_en && wb_cyc_i && wb_stb_i
    && (state_o inside {3'h0, 3'h6}) |=> !wb_ack_o) else $error("ack while asleep");
  a_lp_pins_off: assert property (state_o == 3'h6 && $past(state_o) == 3'h6
    |-> !domain_o.gpio_en && !domain_o.led_en && !domain_o.mgmt_en)
    else $error("pins alive in low power");
  a_lp_exit_boot: assert property ($past(state_o) == 3'h6 && state_o != 3'h6
    |-> state_o == 3'h0 && $past(line_i.energy || line_i.flp)) else $error("bad exit");
  a_lp_from_scan: assert property ($past(state_o) != 3'h6 && state_o == 3'h6
    |-> $past(state_o) == 3'h2) else $error("low power not from scan");
  a_boot_scan: assert property ($past(state_o) == 3'h0 && state_o != 3'h0
    |-> state_o == 3'h2) else $error("boot not to scan");
  a_flp_aneg: assert property ($past(state_o) == 3'h2 && state_o == 3'h3
    |-> $past(line_i.flp)) else $error("aneg without flp");
  a_link_drop: assert property (clk_en && state_o == 3'h4 && !line_i.link_up
    |=> state_o inside {3'h1, 3'h2}) else $error("no return to scan");
  a_refresh_tx: assert property (state_o == 3'h5 && domain_o.refresh
    |-> domain_o.tx_on) else $error("refresh with tx off");
  a_quiet_bound: assert property (quiet_r <= 10'h12c)
    else $error("quiet period too long");
  c_lp_enter: cover property (state_o == 3'h2 ##1 state_o == 3'h6);
  c_lp_exit: cover property (state_o == 3'h6 ##1 state_o == 3'h0);
  c_refresh: cover property (state_o == 3'h5 && domain_o.refresh);
endmodule : pwr_mgr_checker

bind phy_power_state_manager pwr_mgr_checker i_chk (.core_clk(core_clk), .rst(rst),
  .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .line_i(line_i),
  .wb_ack_o(wb_ack_o), .domain_o(domain_o), .state_o(state_o));

// ==== link_partner_model.sv ====
// Purpose: Cable-side link partner
// Assumes: Negotiates while the device is in ANEG
// Notes:   Lines other than speed low with no cable
`timescale 1ns/1ps
module link_partner_model (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    cable,
  input  wire logic                    want_lpi,
  input  wire logic                    wake,
  input  wire logic [1:0]              speed,
  input  wire logic [2:0]              dev_state,
  output pwr_state_pkg::line_in_s      line_o
);
  import pwr_state_pkg::*;
  logic [3:0] neg_r;
  logic [3:0] neg_nxt;
  logic       up_r;
  logic       up_nxt;
  always_comb begin
    neg_nxt = (cable && dev_state == 3'h3) ? neg_r + 4'h1 : 4'h0;
    up_nxt = cable && ((up_r && dev_state inside {3'h3, 3'h4, 3'h5}) || neg_r == 4'hf);
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      neg_r <= 4'h0;
      up_r <= 1'b0;
    end else begin
      neg_r <= neg_nxt;
      up_r <= up_nxt;
    end
  end
  always_comb begin
    line_o.energy = cable;
    line_o.flp = cable && !up_r;
    line_o.link_up = up_r;
    line_o.aneg_done = up_r;
    line_o.lpi_request = up_r && want_lpi;
    line_o.partner_wake = up_r && wake;
    line_o.speed = speed;
  end
endmodule : link_partner_model

// ==== tb_phy_power_state_manager.sv ====
// Purpose: Self-checking bench of the power-state manager
// Assumes: Classic Wishbone host in the bench
// Notes:   Fixed-seed shift register data
`timescale 1ns/1ps
`include "pwr_state_consts.svh"
module tb_phy_power_state_manager;
  import pwr_state_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic [5:0]  wb_adr_i = 6'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'hf;
  logic        wb_we_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  line_in_s    line_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  domain_en_s  domain_o;
  logic        run_ram_image;
  logic [2:0]  state_o;
  logic        cable = 1'b0;
  logic        want_lpi = 1'b0;
  logic        wake = 1'b0;
  logic [1:0]  speed = 2'h0;
  logic [31:0] seed = 32'ha20101f9;
  logic [31:0] q;
  logic [31:0] sv;
  int          n;
  int          n_fail = 0;
  int          samples_checked = 0;
  always #12.5 core_clk = ~core_clk;
  phy_power_state_manager i_dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .line_i(line_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .domain_o(domain_o), .run_ram_image(run_ram_image),
    .state_o(state_o));
  link_partner_model i_lp (.core_clk(core_clk), .rst(rst), .cable(cable),
    .want_lpi(want_lpi), .wake(wake), .speed(speed), .dev_state(state_o), .line_o(line_i));
  // ==========================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb
  task automatic wait_st(input logic [2:0] s);
    n = 0;
    while (state_o !== s && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    chk({29'h0, state_o}, {29'h0, s});
    @(posedge core_clk);
  endtask : wait_st
  task automatic results;
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // ==========================================
  // Tests
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk({29'h0, state_o}, 32'h0);
    wait_st(3'h2);
    wb(1'b0, `OFS_CTRL, 32'h0);
    chk(q, {27'h0, `CTRL_RST});
    wb(1'b0, `OFS_PERSIST, 32'h0);
    chk(q, `PERSIST_RST);
    wb(1'b0, `OFS_ENERGY, 32'h0);
    chk(q, {24'h0, `ENERGY_RST});
    wb(1'b1, 6'h24, 32'hffffffff);
    wb(1'b0, 6'h24, 32'h0);
    chk(q, 32'h0);
    $display("test registers done");
    cable <= 1'b1;
    wait_st(3'h3);
    wait_st(3'h4);
    for (int sp = 0; sp < 3; sp++) begin
      @(posedge core_clk);
      speed <= sp[1:0];
      want_lpi <= 1'b1;
      wait_st(3'h5);
      n = 0;
      while (domain_o.refresh !== 1'b1 && n < 400) begin
        @(negedge core_clk);
        n++;
      end
      chk({31'h0, domain_o.tx_on}, 32'h1);
      n = 0;
      while (domain_o.refresh === 1'b1 && n < 400) begin
        @(negedge core_clk);
        n++;
      end
      chk(n, {16'h0, `REFRESH_CYCLES});
      n = 0;
      while (domain_o.refresh !== 1'b1 && n < 400) begin
        @(negedge core_clk);
        n++;
      end
      chk(n, {16'h0, `QUIET_CYCLES});
      @(posedge core_clk);
      if (sp == 1) wake <= 1'b1;
      else want_lpi <= 1'b0;
      wait_st(3'h4);
      want_lpi <= 1'b0;
      wake <= 1'b0;
    end
    cable <= 1'b0;
    wait_st(3'h2);
    $display("test link and idle done");
    seed = lfsr(seed);
    sv = seed;
    wb(1'b1, `OFS_PERSIST, sv);
    wb(1'b1, `OFS_ENERGY, 32'h0);
    wb(1'b1, `OFS_CTRL, 32'h1);
    wait_st(3'h6);
    chk({29'h0, domain_o.gpio_en, domain_o.led_en, domain_o.mgmt_en}, 32'h0);
    cable <= 1'b1;
    wait_st(3'h0);
    wait_st(3'h2);
    wb(1'b0, `OFS_PERSIST, 32'h0);
    chk(q, sv);
    wb(1'b0, `OFS_CTRL, 32'h0);
    chk(q & 32'h3, 32'h1);
    // Custom control bits restored by the host
    wb(1'b1, `OFS_CTRL, 32'hb);
    wait_st(3'h4);
    cable <= 1'b0;
    repeat (50) @(posedge core_clk);
    wait_st(3'h2);
    wb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk(q & 32'h1, 32'h1);
    wait_st(3'h6);
    cable <= 1'b1;
    wait_st(3'h0);
    wb(1'b1, `OFS_CTRL, 32'h8);
    $display("test low power done");
    for (int m = 0; m < 3; m++) begin
      wb(1'b1, `OFS_FW_CTRL, 32'h1);
      for (int i = 0; i < `FW_WORDS; i++) begin
        seed = lfsr(seed);
        // Word 0 carries the signature, inverted in the second pass
        wb(1'b1, `OFS_FW_DATA, i == 0 ? (m == 1 ? ~`FW_SIG : `FW_SIG) : seed);
        if (m == 2 && i == 3) break;
      end
      wb(1'b1, `OFS_FW_CTRL, m == 2 ? 32'h4 : 32'h2);
      wb(1'b0, `OFS_FW_STATUS, 32'h0);
      chk({30'h0, q[1:0]}, m == 0 ? 32'h2 : 32'h3);
      wb(1'b1, `OFS_FW_CTRL, 32'h8);
      wb(1'b0, `OFS_FW_STATUS, 32'h0);
      chk({31'h0, q[8]}, {31'h0, m == 0});
      chk({31'h0, run_ram_image}, {31'h0, m == 0});
    end
    $display("test firmware done");
    wait_st(3'h4);
    clk_en <= 1'b0;
    cable <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk({29'h0, state_o}, 32'h4);
    clk_en <= 1'b1;
    wait_st(3'h2);
    $display("test clock enable done");
    results();
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end
endmodule : tb_phy_power_state_manager
